// ### include/upbi_pkg.sv
package upbi_pkg;

	// ==========================================
	// Register map
	localparam logic [3:0] CFG_OFFSET    = 4'h0;
	localparam logic [3:0] STATUS_OFFSET = 4'h4;

	// ==========================================
	// Configuration fields
	localparam int CFG_INVERT_BIT = 0;
	localparam int CFG_SENSE_BIT  = 1;
	localparam int CFG_SELF_BIT   = 2;
	localparam int CFG_LOCK_BIT   = 7;

	// ==========================================
	// Status fields
	localparam int STAT_ASSERT_BIT  = 0;
	localparam int STAT_PULLUP_BIT  = 1;
	localparam int STAT_SUSPEND_BIT = 2;
	localparam int STAT_CONFIG_BIT  = 3;
	localparam int STAT_HIGHPWR_BIT = 4;
	localparam int STAT_REFUSED_BIT = 5;
	localparam int STAT_MAXPWR_LSB  = 8;

	// ==========================================
	// Power budget
	localparam logic [7:0] UNIT_LOAD_LIMIT = 8'h32;

	// ==========================================
	// Carriers
	typedef struct packed {
		logic       suspended;
		logic       configured;
		logic [7:0] maxPower;
	} upbi_core_t;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [3:0]  address;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} upbi_avs_req_t;

	// ==========================================
	// Module state
	typedef struct packed {
		logic asserted;
		logic pin;
	} upbi_eval_t;

	typedef struct packed {
		logic pullupEn;
	} upbi_pull_t;

	typedef struct packed {
		logic        respPending;
		logic [31:0] readData;
		logic        cfgLocked;
		logic        invertPolarity;
		logic        senseEnable;
		logic        selfPowered;
		logic        writeRefused;
	} upbi_regs_t;

	// ==========================================
	// Reset values
	localparam upbi_eval_t EVAL_RESET = '{asserted: 1'h1, pin: 1'h0};
	localparam upbi_pull_t PULL_RESET = '{pullupEn: 1'h0};
	localparam upbi_regs_t REGS_RESET = '{
		respPending:    1'h0,
		readData:       32'h0000_0000,
		cfgLocked:      1'h0,
		invertPolarity: 1'h0,
		senseEnable:    1'h0,
		selfPowered:    1'h0,
		writeRefused:   1'h0
	};

endpackage : upbi_pkg

// ### design/upbi_budget_eval.sv
`timescale 1ns/100ps
module upbi_budget_eval (
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	// Device core state
	input  wire upbi_pkg::upbi_core_t coreState,
	input  wire logic                 invertPolarity,
	// Indicator
	output logic                      budgetAsserted,
	output logic                      indicatorPin
);

	// ==========================================
	// State
	upbi_pkg::upbi_eval_t state_ff;
	upbi_pkg::upbi_eval_t nxt_state;
	logic                 highPower;

	// ==========================================
	// Decision
	always_comb begin
		nxt_state = state_ff;
		highPower = coreState.maxPower > upbi_pkg::UNIT_LOAD_LIMIT;
		// Suspend always asserts; high power also while unconfigured
		nxt_state.asserted = coreState.suspended | (highPower & ~coreState.configured);
		// Default level is active low
		nxt_state.pin = nxt_state.asserted ^ ~invertPolarity;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= upbi_pkg::EVAL_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign budgetAsserted = state_ff.asserted;
	assign indicatorPin   = state_ff.pin;

endmodule : upbi_budget_eval

// ### design/upbi_pullup_ctl.sv
`timescale 1ns/100ps
module upbi_pullup_ctl (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst_n,
	// Sense and mode
	input  wire logic busSupplySenseInput,
	input  wire logic selfPowered,
	input  wire logic senseEnable,
	// Pull-up control
	output logic      pullupEn
);

	// ==========================================
	// State
	upbi_pkg::upbi_pull_t state_ff;
	upbi_pkg::upbi_pull_t nxt_state;
	logic                 dropPullup;

	// ==========================================
	// Disconnect decision
	always_comb begin
		nxt_state = state_ff;
		// Sense counts only when enabled and self powered
		dropPullup = selfPowered & senseEnable & ~busSupplySenseInput;
		nxt_state.pullupEn = ~dropPullup;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= upbi_pkg::PULL_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign pullupEn = state_ff.pullupEn;

endmodule : upbi_pullup_ctl

// ### design/usb_power_budget_indicator.sv
// Behaviour
// - Load up to 0x32: indicator asserted only during suspend.
// - Load above 0x32: asserted during suspend and while not configured.
// - Indicator released whenever full requested current may be drawn.
// - Indicator active low by default; configuration can invert it.
// - Self powered: drop D+ pull-up while sense reports bus supply absent.
// - Sense acts only when enabled by configuration, else no effect.
// - Bus powered: sense level is ignored completely.
`timescale 1ns/100ps
module usb_power_budget_indicator (
	// Clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    rst_n,
	// Avalon-MM slave
	input  wire upbi_pkg::upbi_avs_req_t avsReq,
	output logic [31:0]                  readdata,
	output logic                         waitrequest,
	// Device core state
	input  wire upbi_pkg::upbi_core_t    coreState,
	// Supply sense
	input  wire logic                    busSupplySenseInput,
	// Pins
	output logic                         powerBudgetIndicator,
	output logic                         usbPositiveDataLinePullupEn
);

	// ==========================================
	// State
	upbi_pkg::upbi_regs_t state_ff;
	upbi_pkg::upbi_regs_t nxt_state;

	// ==========================================
	// Internal signals
	logic        request;
	logic        accept;
	logic        complete;
	logic        hitCfg;
	logic        hitStatus;
	logic        cfgWrite;
	logic        statusWrite;
	logic        refuseSet;
	logic        refuseClear;
	logic        budgetAsserted;
	logic        indicatorPin;
	logic        pullupEn;
	logic        highPower;
	logic [31:0] cfgWord;
	logic [31:0] statusWord;
	logic [31:0] readWord;

	// ==========================================
	// Bus decode
	assign request   = avsReq.read | avsReq.write;
	assign accept    = request & ~state_ff.respPending;
	assign complete  = request & state_ff.respPending;
	assign hitCfg    = avsReq.address == upbi_pkg::CFG_OFFSET;
	assign hitStatus = avsReq.address == upbi_pkg::STATUS_OFFSET;
	assign highPower = coreState.maxPower > upbi_pkg::UNIT_LOAD_LIMIT;

	// Writes take effect on the edge that completes the transfer, one cycle after the edge that ends the wait
	assign cfgWrite    = complete & avsReq.write & hitCfg & avsReq.byteenable[0];
	assign statusWrite = complete & avsReq.write & hitStatus & avsReq.byteenable[0];
	assign refuseSet   = cfgWrite & state_ff.cfgLocked;
	assign refuseClear = statusWrite & avsReq.writedata[upbi_pkg::STAT_REFUSED_BIT];

	// ==========================================
	// Read words
	always_comb begin
		cfgWord = 32'h0000_0000;
		cfgWord[upbi_pkg::CFG_INVERT_BIT] = state_ff.invertPolarity;
		cfgWord[upbi_pkg::CFG_SENSE_BIT]  = state_ff.senseEnable;
		cfgWord[upbi_pkg::CFG_SELF_BIT]   = state_ff.selfPowered;
		cfgWord[upbi_pkg::CFG_LOCK_BIT]   = state_ff.cfgLocked;
	end

	always_comb begin
		statusWord = 32'h0000_0000;
		statusWord[upbi_pkg::STAT_ASSERT_BIT]  = budgetAsserted;
		statusWord[upbi_pkg::STAT_PULLUP_BIT]  = pullupEn;
		statusWord[upbi_pkg::STAT_SUSPEND_BIT] = coreState.suspended;
		statusWord[upbi_pkg::STAT_CONFIG_BIT]  = coreState.configured;
		statusWord[upbi_pkg::STAT_HIGHPWR_BIT] = highPower;
		statusWord[upbi_pkg::STAT_REFUSED_BIT] = state_ff.writeRefused;
		statusWord[upbi_pkg::STAT_MAXPWR_LSB +: 8] = coreState.maxPower;
	end

	always_comb begin
		readWord = 32'h0000_0000;
		if (hitCfg) begin
			readWord = cfgWord;
		end else if (hitStatus) begin
			readWord = statusWord;
		end
	end

	// ==========================================
	// Register update
	always_comb begin
		nxt_state = state_ff;
		if (accept) begin
			nxt_state.respPending = 1'h1;
			if (avsReq.read) begin
				nxt_state.readData = readWord;
			end else begin
				nxt_state.readData = 32'h0000_0000;
			end
		end else if (state_ff.respPending) begin
			nxt_state.respPending = 1'h0;
		end
		// Configuration is write once, like fused settings
		if (cfgWrite && !state_ff.cfgLocked) begin
			nxt_state.invertPolarity = avsReq.writedata[upbi_pkg::CFG_INVERT_BIT];
			nxt_state.senseEnable    = avsReq.writedata[upbi_pkg::CFG_SENSE_BIT];
			nxt_state.selfPowered    = avsReq.writedata[upbi_pkg::CFG_SELF_BIT];
			nxt_state.cfgLocked      = 1'h1;
		end
		// Set wins over clear
		if (refuseSet) begin
			nxt_state.writeRefused = 1'h1;
		end else if (refuseClear) begin
			nxt_state.writeRefused = 1'h0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= upbi_pkg::REGS_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ==========================================
	// Bus outputs
	assign waitrequest = accept;
	assign readdata    = state_ff.readData;

	// ==========================================
	// Indicator decision
	upbi_budget_eval upbi_budget_eval_i (
		.core_clk       (core_clk),
		.rst_n          (rst_n),
		.coreState      (coreState),
		.invertPolarity (state_ff.invertPolarity),
		.budgetAsserted (budgetAsserted),
		.indicatorPin   (indicatorPin)
	);

	// ==========================================
	// Pull-up control
	upbi_pullup_ctl upbi_pullup_ctl_i (
		.core_clk            (core_clk),
		.rst_n               (rst_n),
		.busSupplySenseInput (busSupplySenseInput),
		.selfPowered         (state_ff.selfPowered),
		.senseEnable         (state_ff.senseEnable),
		.pullupEn            (pullupEn)
	);

	// ==========================================
	// Pin outputs
	assign powerBudgetIndicator        = indicatorPin;
	assign usbPositiveDataLinePullupEn = pullupEn;

	// ==========================================
	// Checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	logic expectAssert;
	assign expectAssert = coreState.suspended | (highPower & ~coreState.configured);

	a_low_power_load: assert property (
		!highPower |=> budgetAsserted == $past(coreState.suspended)
	) else $error("Low power load indicator wrong");

	a_high_power_load: assert property (
		highPower |=> budgetAsserted == $past(coreState.suspended || !coreState.configured)
	) else $error("High power load indicator wrong");

	a_full_draw_release: assert property (
		(!coreState.suspended && (coreState.configured || !highPower)) |=>
			!budgetAsserted && (indicatorPin != $past(state_ff.invertPolarity))
	) else $error("Indicator held while full draw allowed");

	a_pin_polarity: assert property (
		$past(rst_n) |-> powerBudgetIndicator == (budgetAsserted ^ ~$past(state_ff.invertPolarity))
	) else $error("Indicator pin polarity wrong");

	a_sense_disconnect: assert property (
		(state_ff.selfPowered && state_ff.senseEnable && !busSupplySenseInput) |=> !usbPositiveDataLinePullupEn
	) else $error("Pull-up kept without bus supply");

	a_sense_disabled: assert property (
		!state_ff.senseEnable |=> usbPositiveDataLinePullupEn
	) else $error("Sense acted while disabled");

	a_bus_power_ignore: assert property (
		(!state_ff.selfPowered && $changed(busSupplySenseInput)) ##1 !state_ff.selfPowered |->
			usbPositiveDataLinePullupEn [*2]
	) else $error("Sense not ignored when bus powered");

	a_core_reevaluate: assert property (
		$changed(coreState) |=> budgetAsserted == $past(expectAssert)
	) else $error("Indicator missed core change");

	a_bus_one_wait: assert property (
		(request && waitrequest) |=> !waitrequest
	) else $error("Wait state longer than one cycle");

	a_cfg_write_once: assert property (
		(state_ff.cfgLocked && cfgWrite) |=> $stable(state_ff.invertPolarity) && state_ff.writeRefused
	) else $error("Locked configuration changed");

	c_high_power_unconfigured: cover property (
		highPower && !coreState.configured && !coreState.suspended ##1 budgetAsserted
	);

	c_suspend_entry: cover property (
		$rose(coreState.suspended) ##1 budgetAsserted
	);

	c_pullup_dropped: cover property (
		$fell(usbPositiveDataLinePullupEn)
	);

	c_cfg_written: cover property (
		$rose(state_ff.cfgLocked)
	);

endmodule : usb_power_budget_indicator

// ### testbench/upbi_load_model.sv
`timescale 1ns/100ps
module upbi_load_model (
	// Indicator
	input  wire logic indicatorPin,
	input  wire logic invertPolarity,
	// Connector supply
	input  wire logic supplyOn,
	// Load state
	output logic      drawFull,
	output logic      senseLevel
);
	// Full current only at the released level of the indicator
	assign drawFull   = indicatorPin === ~invertPolarity;
	// Divider output follows the supply, pulled to ground when absent
	assign senseLevel = supplyOn;
endmodule : upbi_load_model

// ### testbench/usb_power_budget_indicator_tb.sv
`timescale 1ns/100ps
module usb_power_budget_indicator_tb;
	// ==========================================
	// Signals
	logic                    core_clk;
	logic                    rst_n;
	upbi_pkg::upbi_avs_req_t req;
	logic [31:0]             readdata;
	logic                    waitrequest;
	upbi_pkg::upbi_core_t    core;
	logic                    sense;
	logic                    pin;
	logic                    pullupEn;
	logic                    drawFull;
	logic                    supplyOn;
	logic                    inv;
	int                      failures;
	int                      tests_run;
	int                      cycles;
	logic [31:0]             q;
	logic [7:0]              cfgs [4] = '{8'h00, 8'h02, 8'h04, 8'h07};

	usb_power_budget_indicator usb_power_budget_indicator_i (
		.core_clk                    (core_clk),
		.rst_n                       (rst_n),
		.avsReq                      (req),
		.readdata                    (readdata),
		.waitrequest                 (waitrequest),
		.coreState                   (core),
		.busSupplySenseInput         (sense),
		.powerBudgetIndicator        (pin),
		.usbPositiveDataLinePullupEn (pullupEn)
	);

	upbi_load_model upbi_load_model_i (
		.indicatorPin   (pin),
		.invertPolarity (inv),
		.supplyOn       (supplyOn),
		.drawFull       (drawFull),
		.senseLevel     (sense)
	);

	// ==========================================
	// Clock and timeout
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			failures++;
			results();
		end
	end

	// ==========================================
	// Tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] rd);
		int n;
		n = 0;
		req.read       <= ~wr;
		req.write      <= wr;
		req.address    <= a;
		req.writedata  <= d;
		req.byteenable <= 4'hf;
		do begin
			@(posedge core_clk);
			n++;
		end while (waitrequest !== 1'b0);
		rd = readdata;
		check(n, 32'h2);
		req.read  <= 1'b0;
		req.write <= 1'b0;
		@(posedge core_clk);
	endtask : bus

	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (20) @(posedge core_clk);
		check({30'h0, pin, pullupEn}, 32'h0);
		rst_n <= 1'b1;
		@(posedge core_clk);
	endtask : do_reset

	task automatic wait2();
		repeat (2) @(posedge core_clk);
	endtask : wait2

	task automatic results();
		if (failures == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : results

	// ==========================================
	// Tests
	initial begin
		logic       a;
		logic [7:0] cfg;
		rst_n = 1'b0;
		req = '0;
		core = '0;
		supplyOn = 1'b1;
		inv = 1'b0;
		failures = 0;
		tests_run = 0;
		cycles = 0;
		foreach (cfgs[i]) begin
			cfg = cfgs[i];
			do_reset();
			inv <= cfg[0];
			bus(1'b1, 4'h0, {24'h0, cfg}, q);
			bus(1'b0, 4'h0, 32'h0, q);
			check(q, {24'h0, cfg | 8'h80});
			for (int k = 0; k < 2; k++) begin
				supplyOn <= k[0];
				wait2();
				check({31'h0, pullupEn}, {31'h0, ~(cfg[2] & cfg[1] & ~k[0])});
			end
			for (int k = 0; k < 8; k++) begin
				core <= '{suspended: k[0], configured: k[1], maxPower: k[2] ? 8'h33 : 8'h32};
				wait2();
				a = k[0] | (k[2] & ~k[1]);
				check({31'h0, pin}, {31'h0, cfg[0] ? a : ~a});
				check({31'h0, drawFull}, {31'h0, ~a});
			end
			bus(1'b0, 4'h4, 32'h0, q);
			check(q, 32'h0000_331f);
		end
		bus(1'b1, 4'h0, 32'h0, q);
		bus(1'b0, 4'h0, 32'h0, q);
		check(q, 32'h0000_0087);
		bus(1'b0, 4'h4, 32'h0, q);
		check(q, 32'h0000_333f);
		bus(1'b1, 4'h4, 32'h20, q);
		bus(1'b0, 4'h4, 32'h0, q);
		check(q, 32'h0000_331f);
		bus(1'b0, 4'h8, 32'h0, q);
		check(q, 32'h0);
		results();
	end
endmodule : usb_power_budget_indicator_tb
